// ==== common/warn_check_regs.vh ====
`ifndef WARN_CHECK_REGS_VH
`define WARN_CHECK_REGS_VH

// Register byte offsets
`define OFS_XFER_REQ 8'h00
`define OFS_FLASH_REQ 8'h04
`define OFS_OVERWRITE 8'h08
`define OFS_TORQUE 8'h0C
`define OFS_JOG_SPEED 8'h10
`define OFS_JOG_LIMIT 8'h14
`define OFS_MPG_MAG 8'h18
`define OFS_MPG_SEL 8'h1C
`define OFS_POS_SPEED 8'h20
`define OFS_SPEED_LIMIT 8'h24
`define OFS_START 8'h28
`define OFS_IRQ_STATUS 8'h2C
`define OFS_IRQ_MASK 8'h30
`define OFS_CTRL_STATUS 8'h34
`define OFS_WARN_BASE 8'h40

// Transfer request fields
`define XFER_AXIS_LSB 0
`define XFER_AXIS_MSB 2
`define XFER_DIR_BIT 3
`define XFER_DNO_LSB 4
`define XFER_DNO_MSB 13
`define XFER_PAT_LSB 14
`define XFER_PAT_MSB 15
`define XFER_CNT_LSB 16
`define XFER_CNT_MSB 23
`define XFER_REF_LSB 24
`define XFER_REF_MSB 25

// Value commands: value in low bits, axis in 25:24
`define CMD_AXIS_LSB 24
`define CMD_AXIS_MSB 25
`define START_MPG_BIT 2

// Valid ranges
`define AXIS_FIRST 3'h1
`define AXIS_LAST 3'h4
`define DNO_FIRST 10'h001
`define DNO_LAST 10'h258
`define PAT_LAST 2'h2
`define CNT_FIRST 8'h01
`define CNT_LAST 8'h0A
`define OVR_ZERO_USE 9'h064
`define OVR_MAX 9'h12C
`define TORQUE_MAX 9'h1F4
`define MAG_MAX 8'h64
`define MAG_ZERO_USE 8'h01

// Reset values
`define JOG_LIMIT_RST 24'h00C350
`define SPEED_LIMIT_RST 24'h030D40
`define MPG_SEL_RST 8'h00

// Warning codes (decimal value in binary)
`define W_NONE 12'h000
`define W_START_BUSY 12'h064
`define W_AXIS_BAD 12'h069
`define W_DNO_BAD 12'h06A
`define W_PAT_BAD 12'h06B
`define W_FLASH_FAIL 12'h06C
`define W_WRITE_BUSY 12'h06D
`define W_FLASH_READY 12'h06F
`define W_OVR_BAD 12'h070
`define W_TORQUE_BAD 12'h071
`define W_COUNT_BAD 12'h073
`define W_JOG_DECEL 12'h12C
`define W_JOG_LIMIT 12'h12D
`define W_MAG_BAD 12'h191
`define W_MPG_SEL0 12'h192
`define W_POS_DECEL 12'h1F4
`define W_POS_LIMIT 12'h1F5

// Command kinds on the command strobe
`define K_XFER 4'h1
`define K_FLASH 4'h2
`define K_OVERWRITE 4'h3
`define K_TORQUE 4'h4
`define K_JOG_SPEED 4'h5
`define K_MPG_MAG 4'h6
`define K_POS_SPEED 4'h7
`define K_START 4'h8
`define K_MPG_START 4'h9

`endif

// ==== hw/warn_slot.v ====
`timescale 1ns/1ps
`default_nettype none

module warn_slot (
    // Clock and reset
    input wire clk,
    input wire rst,
    // New warning
    input wire set,
    input wire [11:0] code,
    // Held code
    output reg [11:0] code_reg
);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        code_reg <= 12'h000;
    end else if (set) begin
        code_reg <= code; // [RULE15]
    end
end

endmodule

`default_nettype wire

// ==== hw/warn_check.v ====
// Contract
// [RULE1] A transfer request naming an invalid target axis raises 105 on the reference axis.
// [RULE2] A transfer with a bad data number raises 106, a bad write pattern 107, on the target axis.
// [RULE3] Flash failure raises 108 on axis 1; a flash request while host ready is on raises 111 on axis 1. A bus warning on axis 1 in that cycle wins.
// [RULE4] A write request to a busy axis raises 109; the host asks only while the axis is idle.
// [RULE5] Overwrite value 0 becomes 100, 301 or more becomes 300, each raising 112.
// [RULE6] An out-of-range torque change during operation is dropped and raises 113.
// [RULE7] A transfer with an invalid data count raises 115 on the affected axis.
// [RULE8] A jog speed change during jog-stop deceleration is ignored and raises 300.
// [RULE9] A jog speed over the jog limit runs at the limit, sets the limit flag, raises 301.
// [RULE10] Manual pulse magnification 101 or more clamps to 100, 0 clamps to 1, raising 401.
// [RULE11] A manual pulse start with selection 0 does not start and raises 402.
// [RULE12] A speed change during a deceleration stop is ignored and raises 500.
// [RULE13] A positioning speed change over the speed limit is clamped and raises 501.
// [RULE14] A start on an axis already operating keeps running and raises 100.
// [RULE15] Each axis holds its latest warning code, zero meaning normal, until replaced or reset.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "warn_check_regs.vh"

module warn_check (
    // Clock and reset
    input wire CORE_CLK,
    input wire SYS_RST,
    // Avalon-MM slave
    input wire [7:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    output wire IRQ,
    // Host handshake pins
    input wire HOST_CPU_READY,
    output reg CONTROLLER_READY_OUTPUT,
    // Axis state from motion logic
    input wire [3:0] AXIS_BUSY,
    input wire [3:0] AXIS_OPERATING,
    input wire [3:0] AXIS_JOG_DECEL,
    input wire [3:0] AXIS_STOP_DECEL,
    input wire FLASH_FAIL,
    // Accepted command strobe
    output reg CMD_VALID,
    output reg [3:0] CMD_KIND,
    output reg [1:0] CMD_AXIS,
    output reg [23:0] CMD_VALUE,
    output reg [3:0] SPEED_LIMIT_FLAG
);

////////////////////////////////////////////////////////////////////////////////

function in_range;
    input [23:0] v;
    input [23:0] lo;
    input [23:0] hi;
    begin
        in_range = (v >= lo) && (v <= hi);
    end
endfunction

reg ready_meta_reg;
reg ready_sync_reg;
reg ack_reg;
reg [23:0] jog_limit_reg;
reg [23:0] speed_limit_reg;
reg [7:0] mpg_sel_reg;
reg [3:0] irq_status_reg;
reg [3:0] irq_mask_reg;
wire [11:0] warn_code [0:3];

wire bus_req = AVS_READ | AVS_WRITE;
wire wr_do = AVS_WRITE & ack_reg;
wire [31:0] wd = AVS_WRITEDATA;
wire [1:0] cmd_axis = wd[`CMD_AXIS_MSB:`CMD_AXIS_LSB];

// One wait state: a request is answered at the second edge it is seen
assign AVS_WAITREQUEST = bus_req & ~ack_reg;
assign IRQ = |(irq_status_reg & irq_mask_reg);

////////////////////////////////////////////////////////////////////////////////

// Host ready is a pin from another domain
always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        ready_meta_reg <= 1'b0;
        ready_sync_reg <= 1'b0;
        CONTROLLER_READY_OUTPUT <= 1'b0;
    end else begin
        ready_meta_reg <= HOST_CPU_READY;
        ready_sync_reg <= ready_meta_reg;
        CONTROLLER_READY_OUTPUT <= ready_sync_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////

reg ev_set;
reg [1:0] ev_axis;
reg [11:0] ev_code;
reg cmd_next;
reg [3:0] kind_next;
reg [1:0] axis_next;
reg [23:0] value_next;
reg flag_set;
reg flag_clr;

reg [2:0] x_axis;
reg [1:0] x_ax;
reg [9:0] x_dno;
reg [1:0] x_pat;
reg [7:0] x_cnt;
reg [1:0] x_ref;

always @* begin
    ev_set = 1'b0;
    ev_axis = 2'h0;
    ev_code = `W_NONE;
    cmd_next = 1'b0;
    kind_next = 4'h0;
    axis_next = cmd_axis;
    value_next = 24'h000000;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    x_axis = wd[`XFER_AXIS_MSB:`XFER_AXIS_LSB];
    x_ax = x_axis[1:0] - 2'h1;
    x_dno = wd[`XFER_DNO_MSB:`XFER_DNO_LSB];
    x_pat = wd[`XFER_PAT_MSB:`XFER_PAT_LSB];
    x_cnt = wd[`XFER_CNT_MSB:`XFER_CNT_LSB];
    x_ref = wd[`XFER_REF_MSB:`XFER_REF_LSB];
    if (wr_do) begin
        case (AVS_ADDRESS)
            `OFS_XFER_REQ: begin
                ev_set = 1'b1;
                ev_axis = x_ax;
                if (!in_range({21'h0, x_axis}, {21'h0, `AXIS_FIRST}, {21'h0, `AXIS_LAST})) begin
                    ev_axis = x_ref;
                    ev_code = `W_AXIS_BAD; // [RULE1]
                end else if (!in_range({14'h0, x_dno}, {14'h0, `DNO_FIRST}, {14'h0, `DNO_LAST})) begin
                    ev_code = `W_DNO_BAD; // [RULE2]
                end else if (x_pat > `PAT_LAST) begin
                    ev_code = `W_PAT_BAD; // [RULE2]
                end else if (wd[`XFER_DIR_BIT] && AXIS_BUSY[x_ax]) begin
                    ev_code = `W_WRITE_BUSY; // [RULE4]
                end else if (!in_range({16'h0, x_cnt}, {16'h0, `CNT_FIRST}, {16'h0, `CNT_LAST})) begin
                    ev_code = `W_COUNT_BAD; // [RULE7]
                end else begin
                    ev_set = 1'b0;
                    cmd_next = 1'b1;
                    kind_next = `K_XFER;
                    axis_next = x_ax;
                    value_next = wd[23:0];
                end
            end
            `OFS_FLASH_REQ: begin
                if (ready_sync_reg) begin
                    ev_set = 1'b1;
                    ev_code = `W_FLASH_READY; // [RULE3]
                end else begin
                    cmd_next = 1'b1;
                    kind_next = `K_FLASH;
                    axis_next = 2'h0;
                end
            end
            `OFS_OVERWRITE: begin
                cmd_next = 1'b1;
                kind_next = `K_OVERWRITE;
                value_next = {15'h0, wd[8:0]};
                if (wd[8:0] == 9'h000) begin
                    ev_set = 1'b1;
                    ev_axis = cmd_axis;
                    ev_code = `W_OVR_BAD; // [RULE5]
                    value_next = {15'h0, `OVR_ZERO_USE};
                end else if (wd[8:0] > `OVR_MAX) begin
                    ev_set = 1'b1;
                    ev_axis = cmd_axis;
                    ev_code = `W_OVR_BAD; // [RULE5]
                    value_next = {15'h0, `OVR_MAX};
                end
            end
            `OFS_TORQUE: begin
                if (wd[8:0] == 9'h000 || wd[8:0] > `TORQUE_MAX) begin
                    // Dropped either way; only flagged while the axis runs
                    ev_set = AXIS_OPERATING[cmd_axis];
                    ev_axis = cmd_axis;
                    ev_code = `W_TORQUE_BAD; // [RULE6]
                end else begin
                    cmd_next = 1'b1;
                    kind_next = `K_TORQUE;
                    value_next = {15'h0, wd[8:0]};
                end
            end
            `OFS_JOG_SPEED: begin
                ev_axis = cmd_axis;
                if (AXIS_JOG_DECEL[cmd_axis]) begin
                    ev_set = 1'b1;
                    ev_code = `W_JOG_DECEL; // [RULE8]
                end else begin
                    cmd_next = 1'b1;
                    kind_next = `K_JOG_SPEED;
                    value_next = wd[23:0];
                    flag_clr = 1'b1;
                    if (wd[23:0] > jog_limit_reg) begin
                        value_next = jog_limit_reg; // [RULE9]
                        flag_set = 1'b1;
                        ev_set = 1'b1;
                        ev_code = `W_JOG_LIMIT; // [RULE9]
                    end
                end
            end
            `OFS_MPG_MAG: begin
                cmd_next = 1'b1;
                kind_next = `K_MPG_MAG;
                value_next = {16'h0, wd[7:0]};
                ev_axis = cmd_axis;
                if (wd[7:0] > `MAG_MAX) begin
                    value_next = {16'h0, `MAG_MAX};
                    ev_set = 1'b1;
                    ev_code = `W_MAG_BAD; // [RULE10]
                end else if (wd[7:0] == 8'h00) begin
                    value_next = {16'h0, `MAG_ZERO_USE};
                    ev_set = 1'b1;
                    ev_code = `W_MAG_BAD; // [RULE10]
                end
            end
            `OFS_POS_SPEED: begin
                ev_axis = cmd_axis;
                if (AXIS_STOP_DECEL[cmd_axis]) begin
                    ev_set = 1'b1;
                    ev_code = `W_POS_DECEL; // [RULE12]
                end else begin
                    cmd_next = 1'b1;
                    kind_next = `K_POS_SPEED;
                    value_next = wd[23:0];
                    if (wd[23:0] > speed_limit_reg) begin
                        value_next = speed_limit_reg; // [RULE13]
                        ev_set = 1'b1;
                        ev_code = `W_POS_LIMIT; // [RULE13]
                    end
                end
            end
            `OFS_START: begin
                ev_axis = wd[1:0];
                axis_next = wd[1:0];
                if (AXIS_OPERATING[wd[1:0]]) begin
                    ev_set = 1'b1;
                    ev_code = `W_START_BUSY; // [RULE14]
                end else if (wd[`START_MPG_BIT] && mpg_sel_reg[{wd[1:0], 1'b0} +: 2] == 2'h0) begin
                    ev_set = 1'b1;
                    ev_code = `W_MPG_SEL0; // [RULE11]
                end else begin
                    cmd_next = 1'b1;
                    kind_next = wd[`START_MPG_BIT] ? `K_MPG_START : `K_START;
                    value_next = {22'h0, mpg_sel_reg[{wd[1:0], 1'b0} +: 2]};
                end
            end
            default: begin
                ev_set = 1'b0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////

// Flash failure can land with a bus event; the bus event keeps the slot
wire flash_ev = FLASH_FAIL;
wire [3:0] slot_set;
wire [11:0] slot_code [0:3];

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : slots
        wire bus_hit = ev_set && (ev_axis == g);
        assign slot_set[g] = bus_hit | ((g == 0) & flash_ev);
        assign slot_code[g] = bus_hit ? ev_code : `W_FLASH_FAIL; // [RULE3]
        warn_slot u_slot (
            .clk(CORE_CLK),
            .rst(SYS_RST),
            .set(slot_set[g]),
            .code(slot_code[g]),
            .code_reg(warn_code[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

always @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        ack_reg <= 1'b0;
        AVS_READDATA <= 32'h00000000;
        jog_limit_reg <= `JOG_LIMIT_RST;
        speed_limit_reg <= `SPEED_LIMIT_RST;
        mpg_sel_reg <= `MPG_SEL_RST;
        irq_mask_reg <= 4'h0;
        irq_status_reg <= 4'h0;
        CMD_VALID <= 1'b0;
        CMD_KIND <= 4'h0;
        CMD_AXIS <= 2'h0;
        CMD_VALUE <= 24'h000000;
        SPEED_LIMIT_FLAG <= 4'h0;
    end else begin
        ack_reg <= bus_req & ~ack_reg;
        if (AVS_READ && !ack_reg) begin
            case (AVS_ADDRESS)
                `OFS_JOG_LIMIT: AVS_READDATA <= {8'h00, jog_limit_reg};
                `OFS_SPEED_LIMIT: AVS_READDATA <= {8'h00, speed_limit_reg};
                `OFS_MPG_SEL: AVS_READDATA <= {24'h000000, mpg_sel_reg};
                `OFS_IRQ_STATUS: AVS_READDATA <= {28'h0000000, irq_status_reg};
                `OFS_IRQ_MASK: AVS_READDATA <= {28'h0000000, irq_mask_reg};
                `OFS_CTRL_STATUS: AVS_READDATA <= {23'h000000, SPEED_LIMIT_FLAG,
                                                   AXIS_BUSY, ready_sync_reg};
                `OFS_WARN_BASE: AVS_READDATA <= {20'h00000, warn_code[0]}; // [RULE15]
                `OFS_WARN_BASE + 8'h04: AVS_READDATA <= {20'h00000, warn_code[1]};
                `OFS_WARN_BASE + 8'h08: AVS_READDATA <= {20'h00000, warn_code[2]};
                `OFS_WARN_BASE + 8'h0C: AVS_READDATA <= {20'h00000, warn_code[3]};
                default: AVS_READDATA <= 32'h00000000;
            endcase
        end
        if (wr_do) begin
            case (AVS_ADDRESS)
                `OFS_JOG_LIMIT: jog_limit_reg <= wd[23:0];
                `OFS_SPEED_LIMIT: speed_limit_reg <= wd[23:0];
                `OFS_MPG_SEL: mpg_sel_reg <= wd[7:0];
                `OFS_IRQ_MASK: irq_mask_reg <= wd[3:0];
                default: irq_mask_reg <= irq_mask_reg;
            endcase
        end
        // New warnings win over a write-one-to-clear in the same cycle
        irq_status_reg <= (irq_status_reg &
                           ~((wr_do && AVS_ADDRESS == `OFS_IRQ_STATUS) ? wd[3:0] : 4'h0))
                          | slot_set;
        CMD_VALID <= cmd_next;
        if (cmd_next) begin
            CMD_KIND <= kind_next;
            CMD_AXIS <= axis_next;
            CMD_VALUE <= value_next;
        end
        if (flag_set) begin
            SPEED_LIMIT_FLAG[cmd_axis] <= 1'b1; // [RULE9]
        end else if (flag_clr) begin
            SPEED_LIMIT_FLAG[cmd_axis] <= 1'b0;
        end
    end
end

endmodule

`default_nettype wire

// ==== verification/warn_check_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "warn_check_regs.vh"
module warn_check_props (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Bus handshake
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    // Host pins and axis state
    input wire logic HOST_CPU_READY,
    input wire logic CONTROLLER_READY_OUTPUT,
    input wire logic [3:0] AXIS_JOG_DECEL,
    input wire logic [3:0] AXIS_STOP_DECEL,
    // Command strobe
    input wire logic CMD_VALID,
    input wire logic [3:0] CMD_KIND,
    input wire logic [1:0] CMD_AXIS,
    input wire logic [23:0] CMD_VALUE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    wait_once_a: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("wait state longer than one cycle");
    cmd_cause_a: assert property (
        CMD_VALID |-> $past(AVS_WRITE && !AVS_WAITREQUEST) ##1 !CMD_VALID)
        else $error("command strobe without a completed write");
    ovr_range_a: assert property (
        CMD_VALID && CMD_KIND == `K_OVERWRITE |-> CMD_VALUE inside {[24'h000001:24'h00012C]})
        else $error("overwrite value not clamped");
    torque_range_a: assert property (
        CMD_VALID && CMD_KIND == `K_TORQUE |-> CMD_VALUE inside {[24'h000001:24'h0001F4]})
        else $error("torque out of range accepted");
    mag_range_a: assert property (
        CMD_VALID && CMD_KIND == `K_MPG_MAG |-> CMD_VALUE inside {[24'h000001:24'h000064]})
        else $error("magnification not clamped");
    mpg_sel_a: assert property (
        CMD_VALID && CMD_KIND == `K_MPG_START |-> CMD_VALUE != 24'h000000)
        else $error("manual pulse start with selection zero");
    ready_follow_a: assert property (
        HOST_CPU_READY [*4] |=> CONTROLLER_READY_OUTPUT)
        else $error("controller ready does not follow host ready");
    // The decel level is taken at the accepting edge, indexed by the new command's axis
    jog_decel_a: assert property (
        CMD_VALID && CMD_KIND == `K_JOG_SPEED |-> (($past(AXIS_JOG_DECEL) >> CMD_AXIS) & 4'h1) == 4'h0)
        else $error("jog speed change taken during deceleration");
    pos_decel_a: assert property (
        CMD_VALID && CMD_KIND == `K_POS_SPEED |-> (($past(AXIS_STOP_DECEL) >> CMD_AXIS) & 4'h1) == 4'h0)
        else $error("speed change taken during stop deceleration");
    cover property (CMD_VALID && CMD_KIND == `K_JOG_SPEED);
    cover property (CMD_VALID && CMD_KIND == `K_TORQUE);
    cover property (CMD_VALID && CMD_KIND == `K_MPG_START);
    cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind warn_check warn_check_props u_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .HOST_CPU_READY(HOST_CPU_READY), .CONTROLLER_READY_OUTPUT(CONTROLLER_READY_OUTPUT),
    .AXIS_JOG_DECEL(AXIS_JOG_DECEL), .AXIS_STOP_DECEL(AXIS_STOP_DECEL), .CMD_VALID(CMD_VALID),
    .CMD_KIND(CMD_KIND), .CMD_AXIS(CMD_AXIS), .CMD_VALUE(CMD_VALUE));
`default_nettype wire

// ==== verification/host_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    // Clock
    input wire logic clk,
    // Avalon master side
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
    end
    // Request held until waitrequest is seen low; released data is inverted
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        writedata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== verification/positioning_warning_checker_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "warn_check_regs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module positioning_warning_checker_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hrdy = 1'b0;
    logic ffail = 1'b0;
    logic [3:0] busy = 4'h0, oper = 4'h0, jdec = 4'h0, sdec = 4'h0;
    wire [7:0] addr;
    wire [31:0] wd, rdata;
    wire rd_s, wr_s, wt, irq, cro, cv;
    wire [3:0] ck, lf;
    wire [1:0] ca;
    wire [23:0] cval;
    int err_total = 0;
    int samples_checked = 0;
    always #20 clk = ~clk;
    host_cpu_model u_host (.clk(clk), .address(addr), .read(rd_s), .write(wr_s),
        .writedata(wd), .readdata(rdata), .waitrequest(wt));
    warn_check u_warn_check (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
        .AVS_WRITE(wr_s), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wt),
        .IRQ(irq), .HOST_CPU_READY(hrdy), .CONTROLLER_READY_OUTPUT(cro), .AXIS_BUSY(busy),
        .AXIS_OPERATING(oper), .AXIS_JOG_DECEL(jdec), .AXIS_STOP_DECEL(sdec), .FLASH_FAIL(ffail),
        .CMD_VALID(cv), .CMD_KIND(ck), .CMD_AXIS(ca), .CMD_VALUE(cval), .SPEED_LIMIT_FLAG(lf));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic warn(input logic [7:0] ax, input logic [11:0] code);
        logic [31:0] d;
        u_host.rd(`OFS_WARN_BASE + 8'(4 * (ax - 8'h01)), d);
        `CHK(d[11:0], code)
    endtask
    // Strobe is due in the cycle after the completing edge
    task automatic cmd(input logic [3:0] k, input logic [1:0] a, input logic [23:0] v);
        #1;
        `CHK(cv, 1'b1)
        `CHK(ck, k)
        `CHK(ca, a)
        `CHK(cval, v)
    endtask
    task automatic nocmd;
        #1;
        `CHK(cv, 1'b0)
    endtask
    task automatic irqchk(input logic e);
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_xfer;
        for (int i = 1; i <= 4; i++) warn(8'(i), `W_NONE);
        u_host.wr(`OFS_XFER_REQ, 32'h01000008);
        warn(8'h02, `W_AXIS_BAD);
        u_host.wr(`OFS_XFER_REQ, 32'h0001000B);
        warn(8'h03, `W_DNO_BAD);
        u_host.wr(`OFS_XFER_REQ, 32'h0001C01B);
        warn(8'h03, `W_PAT_BAD);
        u_host.wr(`OFS_XFER_REQ, 32'h000B001B);
        warn(8'h03, `W_COUNT_BAD);
        @(posedge clk) busy <= 4'h2;
        u_host.wr(`OFS_XFER_REQ, 32'h0001001A);
        nocmd();
        warn(8'h02, `W_WRITE_BUSY);
        @(posedge clk) busy <= 4'h0;
        u_host.wr(`OFS_XFER_REQ, 32'h000A258A);
        cmd(`K_XFER, 2'h1, 24'h0A258A);
        $display("test xfer done");
    endtask
    task automatic t_flash;
        @(posedge clk) hrdy <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(cro, 1'b1)
        u_host.wr(`OFS_FLASH_REQ, 32'h00000000);
        warn(8'h01, `W_FLASH_READY);
        @(posedge clk) hrdy <= 1'b0;
        @(posedge clk) ffail <= 1'b1;
        @(posedge clk) ffail <= 1'b0;
        warn(8'h01, `W_FLASH_FAIL);
        `CHK(cro, 1'b0)
        u_host.wr(`OFS_FLASH_REQ, 32'h00000000);
        cmd(`K_FLASH, 2'h0, 24'h000000);
        $display("test flash done");
    endtask
    task automatic t_values;
        u_host.wr(`OFS_OVERWRITE, 32'h00000000);
        cmd(`K_OVERWRITE, 2'h0, 24'h000064);
        warn(8'h01, `W_OVR_BAD);
        u_host.wr(`OFS_OVERWRITE, 32'h0300012D);
        cmd(`K_OVERWRITE, 2'h3, 24'h00012C);
        warn(8'h04, `W_OVR_BAD);
        @(posedge clk) oper <= 4'h1;
        u_host.wr(`OFS_TORQUE, 32'h000001F5);
        nocmd();
        warn(8'h01, `W_TORQUE_BAD);
        u_host.wr(`OFS_TORQUE, 32'h000001F4);
        cmd(`K_TORQUE, 2'h0, 24'h0001F4);
        u_host.wr(`OFS_START, 32'h00000000);
        nocmd();
        warn(8'h01, `W_START_BUSY);
        u_host.wr(`OFS_MPG_MAG, 32'h01000065);
        cmd(`K_MPG_MAG, 2'h1, 24'h000064);
        warn(8'h02, `W_MAG_BAD);
        u_host.wr(`OFS_MPG_MAG, 32'h00000000);
        cmd(`K_MPG_MAG, 2'h0, 24'h000001);
        u_host.wr(`OFS_START, 32'h00000005);
        nocmd();
        warn(8'h02, `W_MPG_SEL0);
        // Selection 1 for the second axis only
        u_host.wr(`OFS_MPG_SEL, 32'h00000004);
        u_host.wr(`OFS_START, 32'h00000005);
        cmd(`K_MPG_START, 2'h1, 24'h000001);
        u_host.wr(`OFS_START, 32'h00000002);
        cmd(`K_START, 2'h2, 24'h000000);
        $display("test values done");
    endtask
    task automatic t_speed;
        logic [31:0] d;
        u_host.wr(`OFS_JOG_SPEED, 32'h0000EA60);
        cmd(`K_JOG_SPEED, 2'h0, `JOG_LIMIT_RST);
        `CHK(lf[0], 1'b1)
        warn(8'h01, `W_JOG_LIMIT);
        u_host.rd(`OFS_CTRL_STATUS, d);
        `CHK(d, 32'h00000020)
        u_host.wr(`OFS_JOG_SPEED, 32'h00000064);
        cmd(`K_JOG_SPEED, 2'h0, 24'h000064);
        `CHK(lf[0], 1'b0)
        @(posedge clk) jdec <= 4'h1;
        u_host.wr(`OFS_JOG_SPEED, 32'h00000064);
        nocmd();
        warn(8'h01, `W_JOG_DECEL);
        u_host.rd(`OFS_SPEED_LIMIT, d);
        `CHK(d, {8'h00, `SPEED_LIMIT_RST})
        u_host.wr(`OFS_POS_SPEED, 32'h01030D41);
        cmd(`K_POS_SPEED, 2'h1, `SPEED_LIMIT_RST);
        warn(8'h02, `W_POS_LIMIT);
        @(posedge clk) sdec <= 4'h2;
        u_host.wr(`OFS_POS_SPEED, 32'h01000064);
        nocmd();
        warn(8'h02, `W_POS_DECEL);
        $display("test speed done");
    endtask
    task automatic t_irq;
        logic [31:0] d;
        u_host.wr(`OFS_IRQ_MASK, 32'h0000000F);
        irqchk(1'b1);
        u_host.wr(`OFS_IRQ_STATUS, 32'h0000000F);
        irqchk(1'b0);
        u_host.wr(`OFS_MPG_MAG, 32'h00000000);
        irqchk(1'b1);
        u_host.wr(`OFS_IRQ_MASK, 32'h00000000);
        irqchk(1'b0);
        u_host.rd(8'h3C, d);
        `CHK(d, 32'h00000000)
        // A reset in mid-run must return the held code of axis 1 to normal
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        warn(8'h01, `W_NONE);
        u_host.rd(`OFS_JOG_LIMIT, d);
        `CHK(d, {8'h00, `JOG_LIMIT_RST})
        $display("test irq done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_xfer();
        t_flash();
        t_values();
        t_speed();
        t_irq();
        report_and_stop();
    end
    // Whole sequence needs well under 1000 cycles
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
